/* File: bus_master_model.sv */
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic                      clock,
  input  wire logic                      flashReadyFlag,
  input  wire logic                      latchWriteDone,
  output flash_seq_pkg::latch_write_type latchWrite,
  output flash_seq_pkg::command_req_type commandReq
);
  // Handshakes that never answer are counted here
  int timeouts;
  initial begin
    latchWrite = '0;
    commandReq = '0;
    timeouts   = 0;
  end
  task automatic put_word(input logic [3:0] idx, input logic [31:0] data);
    @(posedge clock) #1;
    latchWrite = {1'b1, idx, data};
    @(posedge clock) #1;
    latchWrite.valid = 1'b0;
    // Released bus must not keep showing the old word
    latchWrite.data = ~data;
    repeat (40) if (!latchWriteDone) @(posedge clock) #1;
    if (!latchWriteDone) timeouts++;
  endtask : put_word
  // command after the latch is filled
  task automatic put_cmd(input flash_seq_pkg::command_type code, input logic [3:0] page);
    @(posedge clock) #1;
    commandReq = {1'b1, code, page};
    @(posedge clock) #1;
    commandReq.valid = 1'b0;
    repeat (600) if (!flashReadyFlag) @(posedge clock) #1;
    if (!flashReadyFlag) timeouts++;
  endtask : put_cmd
endmodule : bus_master_model

/* File: flash_program_latch_sequencer.sv */
`timescale 1ns/1ns
// Functional notes
// - Programming only clears bits to zero
// - Erase-write commands erase page first
// - Lock commands set region lock afterwards
// - Set lock blocks writes and erases
// - Latch decodes whole range, index wraps
// - Latch writes take read wait states
// - Latch refilled with ones after command
// - Command write clears ready flag at once
// - Descriptor words in fixed documented order
module flash_program_latch_sequencer #(
  parameter int PAGE_WORDS   = flash_seq_pkg::PAGE_WORDS,
  parameter int PAGE_COUNT   = flash_seq_pkg::PAGE_COUNT,
  parameter int LOCK_REGIONS = flash_seq_pkg::LOCK_REGIONS
) (
  input  wire logic                                   clock,
  input  wire logic                                   rst,
  input  wire flash_seq_pkg::latch_write_type         latchWrite,
  input  wire logic [flash_seq_pkg::WAIT_BITS-1:0]    readWaitStates,
  output logic                                        latchWriteDone,
  input  wire flash_seq_pkg::command_req_type         commandReq,
  output logic                                        flashReadyFlag,
  output logic                                        lockErrorFlag,
  output logic [LOCK_REGIONS-1:0]                     lockBits,
  input  wire logic [flash_seq_pkg::IDX_BITS+flash_seq_pkg::PAGE_BITS-1:0] readAddr,
  output logic [flash_seq_pkg::WORD_BITS-1:0]         readData,
  input  wire logic [3:0]                             descIndex,
  output logic [flash_seq_pkg::WORD_BITS-1:0]         descData
);

  localparam int AW          = flash_seq_pkg::IDX_BITS + flash_seq_pkg::PAGE_BITS;
  localparam int PAGES_PER_L = PAGE_COUNT / LOCK_REGIONS;
  localparam int PAGE_BYTES  = PAGE_WORDS * 4;

  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_LOCK, ST_ERASE_ALL} phase_type;

  typedef struct packed {
    phase_type                                   phase;
    flash_seq_pkg::command_type                  code;
    logic [flash_seq_pkg::PAGE_BITS-1:0]         page;
    logic [flash_seq_pkg::IDX_BITS-1:0]          word;
    logic                                        ready;
    logic                                        lockErr;
    logic [LOCK_REGIONS-1:0]                     locks;
    logic                                        wrPending;
    logic                                        wrDone;
    logic                                        timerStart;
    logic [flash_seq_pkg::WAIT_BITS-1:0]         timerCount;
    logic [flash_seq_pkg::WORD_BITS-1:0]         rdData;
    logic [flash_seq_pkg::WORD_BITS-1:0]         descData;
  } state_type;

  state_type state_q;
  state_type state_d;

  // Memories live here: latch buffer and flash array
  logic [flash_seq_pkg::WORD_BITS-1:0] latchMem [PAGE_WORDS];
  logic [flash_seq_pkg::WORD_BITS-1:0] flashMem [PAGE_COUNT*PAGE_WORDS];

  localparam int LOCK_BITS_W = (LOCK_REGIONS > 1) ? $clog2(LOCK_REGIONS) : 1;
  logic timerDone;
  logic [LOCK_BITS_W-1:0] regionOfCmd;

  wait_counter #(
    .WIDTH (flash_seq_pkg::WAIT_BITS)
  ) u_timer (
    .clock (clock),
    .rst   (rst),
    .start (state_q.timerStart),
    .count (state_q.timerCount),
    .done  (timerDone)
  );

  assign regionOfCmd = LOCK_BITS_W'(commandReq.page / PAGES_PER_L);

  function automatic logic [flash_seq_pkg::WORD_BITS-1:0] descWord(input logic [3:0] idx);
    logic [flash_seq_pkg::WORD_BITS-1:0] w;
    w = '0;
    case (idx)
      flash_seq_pkg::DESC_IDX_INTERFACE: w = flash_seq_pkg::DESC_INTERFACE_VALUE;
      flash_seq_pkg::DESC_IDX_TOTAL:     w = 32'(PAGE_COUNT * PAGE_BYTES);
      flash_seq_pkg::DESC_IDX_PAGE:      w = 32'(PAGE_BYTES);
      flash_seq_pkg::DESC_IDX_PLANES:    w = 32'h0000_0001;
      flash_seq_pkg::DESC_IDX_PLANE0:    w = 32'(PAGE_COUNT * PAGE_BYTES);
      flash_seq_pkg::DESC_IDX_LOCKCNT:   w = 32'(LOCK_REGIONS);
      default: begin
        if (idx >= flash_seq_pkg::DESC_IDX_LOCK0
            && 32'(idx) < 32'(flash_seq_pkg::DESC_IDX_LOCK0) + 32'(LOCK_REGIONS)) begin
          w = 32'(PAGES_PER_L * PAGE_BYTES);
        end
      end
    endcase
    return w;
  endfunction : descWord

  always_comb begin
    state_d            = state_q;
    state_d.wrDone     = 1'b0;
    state_d.timerStart = 1'b0;
    state_d.rdData     = flashMem[readAddr];
    state_d.descData   = descWord(descIndex);
    // latch write waits read wait states
    if (latchWrite.valid && !state_q.wrPending) begin
      state_d.wrPending  = 1'b1;
      state_d.timerStart = 1'b1;
      state_d.timerCount = readWaitStates;
    end else if (state_q.wrPending && timerDone) begin
      state_d.wrPending = 1'b0;
      state_d.wrDone    = 1'b1;
    end
    case (state_q.phase)
      ST_IDLE: begin
        if (commandReq.valid) begin
          // ready cleared by the command write
          state_d.ready = 1'b0;
          state_d.code  = commandReq.code;
          state_d.page  = commandReq.page;
          state_d.word  = '0;
          // locked region refuses the command
          // Plane erase touches every region, so any set lock refuses it
          if ((commandReq.code == flash_seq_pkg::CMD_ERASE_ALL && |state_q.locks)
              || (commandReq.code != flash_seq_pkg::CMD_ERASE_ALL && state_q.locks[regionOfCmd])) begin
            state_d.lockErr = 1'b1;
            state_d.phase   = ST_LOCK;
            state_d.code    = flash_seq_pkg::CMD_WRITE_PAGE;
          end else begin
            state_d.lockErr = 1'b0;
            case (commandReq.code)
              flash_seq_pkg::CMD_ERASE_WRITE,
              flash_seq_pkg::CMD_ERASE_WRITE_LOCK,
              flash_seq_pkg::CMD_ERASE_PAGE: state_d.phase = ST_ERASE;
              flash_seq_pkg::CMD_ERASE_ALL: begin
                state_d.phase = ST_ERASE_ALL;
                state_d.page  = '0;
              end
              default:                       state_d.phase = ST_PROG;
            endcase
          end
        end
      end
      ST_ERASE, ST_ERASE_ALL: begin
        if (state_q.word == flash_seq_pkg::IDX_BITS'(PAGE_WORDS - 1)) begin
          state_d.word = '0;
          if (state_q.phase == ST_ERASE_ALL && state_q.page != flash_seq_pkg::PAGE_BITS'(PAGE_COUNT - 1)) begin
            state_d.page = state_q.page + 1'b1;
          end else if (state_q.code == flash_seq_pkg::CMD_ERASE_PAGE || state_q.phase == ST_ERASE_ALL) begin
            state_d.phase = ST_LOCK;
          end else begin
            state_d.phase = ST_PROG;
          end
        end else begin
          state_d.word = state_q.word + 1'b1;
        end
      end
      ST_PROG: begin
        if (state_q.word == flash_seq_pkg::IDX_BITS'(PAGE_WORDS - 1)) begin
          state_d.phase = ST_LOCK;
        end else begin
          state_d.word = state_q.word + 1'b1;
        end
      end
      ST_LOCK: begin
        if (state_q.code == flash_seq_pkg::CMD_WRITE_LOCK || state_q.code == flash_seq_pkg::CMD_ERASE_WRITE_LOCK) begin
          state_d.locks[LOCK_BITS_W'(state_q.page / PAGES_PER_L)] = 1'b1;
        end
        state_d.ready = 1'b1;
        state_d.phase = ST_IDLE;
      end
      default: state_d.phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q       <= '0;
      state_q.phase <= ST_IDLE;
      state_q.ready <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Array writes; reset leaves contents alone, flash is nonvolatile
  always_ff @(posedge clock) begin
    if (latchWrite.valid && !state_q.wrPending) begin
      latchMem[latchWrite.index] <= latchWrite.data;
    end
    if (state_q.phase == ST_ERASE || state_q.phase == ST_ERASE_ALL) begin
      flashMem[{state_q.page, state_q.word}] <= flash_seq_pkg::ERASED_WORD;
    end else if (state_q.phase == ST_PROG) begin
      flashMem[{state_q.page, state_q.word}] <= flashMem[{state_q.page, state_q.word}] & latchMem[state_q.word];
    end
    if (state_q.phase == ST_LOCK) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        latchMem[i] <= flash_seq_pkg::ERASED_WORD;
      end
    end
  end

  assign latchWriteDone = state_q.wrDone;
  assign flashReadyFlag = state_q.ready;
  assign lockErrorFlag  = state_q.lockErr;
  assign lockBits       = state_q.locks;
  assign readData       = state_q.rdData;
  assign descData       = state_q.descData;

endmodule : flash_program_latch_sequencer

/* File: flash_program_latch_sequencer_tb_top.sv */
`timescale 1ns/1ns
module flash_program_latch_sequencer_tb_top;
  logic                           clock;
  logic                           rst;
  logic [3:0]                     readWaitStates;
  logic [7:0]                     readAddr;
  logic [3:0]                     descIndex;
  logic                           latchWriteDone;
  logic                           flashReadyFlag;
  logic                           lockErrorFlag;
  logic [3:0]                     lockBits;
  logic [31:0]                    readData;
  logic [31:0]                    descData;
  flash_seq_pkg::latch_write_type latchWrite;
  flash_seq_pkg::command_req_type commandReq;
  int                             failures;
  int                             cmpCount;
  flash_program_latch_sequencer u_dut (.clock(clock), .rst(rst), .latchWrite(latchWrite),
    .readWaitStates(readWaitStates), .latchWriteDone(latchWriteDone), .commandReq(commandReq),
    .flashReadyFlag(flashReadyFlag), .lockErrorFlag(lockErrorFlag), .lockBits(lockBits),
    .readAddr(readAddr), .readData(readData), .descIndex(descIndex), .descData(descData));
  bus_master_model u_master (.clock(clock), .flashReadyFlag(flashReadyFlag),
    .latchWriteDone(latchWriteDone), .latchWrite(latchWrite), .commandReq(commandReq));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] expected, input logic [31:0] seen);
    cmpCount++;
    if (seen !== expected) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, expected, seen);
    end
  endtask : check
  task automatic read_word(input logic [7:0] addr, input logic [31:0] expected);
    @(posedge clock) #1;
    readAddr = addr;
    @(posedge clock) #1;
    check("flash word", expected, readData);
  endtask : read_word
  task automatic fill_page(input logic [31:0] base);
    for (int i = 0; i < 16; i++) u_master.put_word(4'(i), base + 32'(i));
  endtask : fill_page
  task automatic end_of_test;
    failures += u_master.timeouts;
    $display("mismatches %0d comparisons %0d", failures, cmpCount);
    if (failures == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] desc_word(input int i);
    case (i)
      0: return flash_seq_pkg::DESC_INTERFACE_VALUE;
      1, 4: return 32'h0000_0400;
      2: return 32'h0000_0040;
      3: return 32'h0000_0001;
      5: return 32'h0000_0004;
      6, 7, 8, 9: return 32'h0000_0100;
      default: return 32'h0000_0000;
    endcase
  endfunction : desc_word
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Whole sequence needs under a thousand cycles
  initial begin
    #1_000_000;
    failures++;
    end_of_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    readWaitStates = 4'h2;
    readAddr = 8'h00;
    descIndex = 4'h0;
    failures = 0;
    cmpCount = 0;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    check("ready", 32'h1, {31'h0, flashReadyFlag});
    check("locks", 32'h0, {28'h0, lockBits});
    for (int i = 0; i < 11; i++) begin
      @(posedge clock) #1;
      descIndex = 4'(i);
      @(posedge clock) #1;
      check("descriptor", desc_word(i), descData);
    end
    u_master.put_cmd(flash_seq_pkg::CMD_ERASE_ALL, 4'h0);
    read_word(8'h25, 32'hffff_ffff);
    readWaitStates = 4'h5;
    fill_page(32'h1234_5600);
    u_master.put_cmd(flash_seq_pkg::CMD_ERASE_WRITE, 4'h2);
    read_word(8'h20, 32'h1234_5600);
    read_word(8'h2f, 32'h1234_560f);
    u_master.put_word(4'h3, 32'h0f0f_ff00);
    u_master.put_cmd(flash_seq_pkg::CMD_WRITE_PAGE, 4'h2);
    read_word(8'h23, 32'h0204_5600);
    read_word(8'h24, 32'h1234_5604);
    fill_page(32'h0000_aa00);
    u_master.put_cmd(flash_seq_pkg::CMD_ERASE_WRITE_LOCK, 4'h5);
    check("locks", 32'h2, {28'h0, lockBits});
    u_master.put_word(4'h0, 32'h0000_0000);
    u_master.put_cmd(flash_seq_pkg::CMD_ERASE_WRITE, 4'h5);
    check("lock error", 32'h1, {31'h0, lockErrorFlag});
    read_word(8'h50, 32'h0000_aa00);
    u_master.put_cmd(flash_seq_pkg::CMD_WRITE_LOCK, 4'hc);
    check("lock error", 32'h0, {31'h0, lockErrorFlag});
    check("locks", 32'ha, {28'h0, lockBits});
    read_word(8'hc0, 32'hffff_ffff);
    u_master.put_cmd(flash_seq_pkg::CMD_ERASE_ALL, 4'h0);
    check("erase all refused", 32'h1, {31'h0, lockErrorFlag});
    read_word(8'h51, 32'h0000_aa01);
    u_master.put_cmd(flash_seq_pkg::CMD_ERASE_PAGE, 4'h2);
    read_word(8'h23, 32'hffff_ffff);
    end_of_test();
  end
endmodule : flash_program_latch_sequencer_tb_top

/* File: flash_seq_pkg.sv */
package flash_seq_pkg;

  // ************************************************
  // Geometry defaults
  // ************************************************
  localparam int PAGE_WORDS      = 16;
  localparam int PAGE_COUNT      = 16;
  localparam int LOCK_REGIONS    = 4;
  localparam int WORD_BITS       = 32;
  localparam int PAGE_BITS       = 4;
  localparam int IDX_BITS        = 4;
  localparam int LOCK_BITS       = 2;
  localparam int WAIT_BITS       = 4;

  // ************************************************
  // Descriptor word indices
  // ************************************************
  localparam logic [3:0] DESC_IDX_INTERFACE = 4'h0;
  localparam logic [3:0] DESC_IDX_TOTAL     = 4'h1;
  localparam logic [3:0] DESC_IDX_PAGE      = 4'h2;
  localparam logic [3:0] DESC_IDX_PLANES    = 4'h3;
  localparam logic [3:0] DESC_IDX_PLANE0    = 4'h4;
  localparam logic [3:0] DESC_IDX_LOCKCNT   = 4'h5;
  localparam logic [3:0] DESC_IDX_LOCK0     = 4'h6;
  // Arbitrary value, not a real part identity
  localparam logic [31:0] DESC_INTERFACE_VALUE = 32'h0000_0001;

  // ************************************************
  // Erased word value and timing counts
  // ************************************************
  localparam logic [31:0] ERASED_WORD   = 32'hffff_ffff;
  localparam int          ERASE_CYCLES  = 8;
  localparam int          PROG_CYCLES   = 4;
  localparam int          LOCK_CYCLES   = 2;

  typedef enum logic [2:0] {
    CMD_WRITE_PAGE,
    CMD_ERASE_WRITE,
    CMD_WRITE_LOCK,
    CMD_ERASE_WRITE_LOCK,
    CMD_ERASE_PAGE,
    CMD_ERASE_ALL
  } command_type;

  typedef struct packed {
    logic                 valid;
    logic [IDX_BITS-1:0]  index;
    logic [WORD_BITS-1:0] data;
  } latch_write_type;

  typedef struct packed {
    logic                  valid;
    command_type           code;
    logic [PAGE_BITS-1:0]  page;
  } command_req_type;

endpackage : flash_seq_pkg

/* File: flash_seq_props.sv */
`timescale 1ns/1ns
module flash_seq_props #(
  parameter int LOCK_REGIONS = 4
) (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire flash_seq_pkg::latch_write_type latchWrite,
  input  wire logic                           latchWriteDone,
  input  wire logic [3:0]                     readWaitStates,
  input  wire flash_seq_pkg::command_req_type commandReq,
  input  wire logic                           flashReadyFlag,
  input  wire logic                           lockErrorFlag,
  input  wire logic [LOCK_REGIONS-1:0]        lockBits,
  input  wire logic [3:0]                     descIndex,
  input  wire logic [31:0]                    descData
);
  logic       take;
  logic       hit;
  logic [1:0] region_q;
  logic       wrBusy_q;
  logic [7:0] wrAge_q;
  assign take = commandReq.valid && flashReadyFlag;
  assign hit  = (commandReq.code == flash_seq_pkg::CMD_ERASE_ALL) ? |lockBits : lockBits[commandReq.page[3:2]];
  always_ff @(posedge clock) begin
    if (rst) begin
      wrBusy_q <= 1'b0;
      wrAge_q  <= 8'h00;
    end else if (latchWriteDone) begin
      wrBusy_q <= 1'b0;
    end else if (latchWrite.valid && !wrBusy_q) begin
      wrBusy_q <= 1'b1;
      wrAge_q  <= 8'h01;
    end else if (wrBusy_q) begin
      wrAge_q <= wrAge_q + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (take) begin
      region_q <= commandReq.page[3:2];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ****************************************
  // Properties
  // ****************************************
  property p_ready_clear; take |=> !flashReadyFlag; endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");
  property p_erase_first;
    take && commandReq.code == flash_seq_pkg::CMD_ERASE_WRITE && !hit |=> !flashReadyFlag [*8] ##24 !flashReadyFlag;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("erase phase missing");
  property p_ready_back; $fell(flashReadyFlag) |-> ##[1:400] flashReadyFlag; endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready never returned");
  property p_lock_hit;
    take && hit |-> ##[2:4] (flashReadyFlag && lockErrorFlag);
  endproperty
  a_lock_hit: assert property (p_lock_hit) else $error("locked region not refused");
  property p_lock_set;
    take && !hit && commandReq.code inside {flash_seq_pkg::CMD_WRITE_LOCK, flash_seq_pkg::CMD_ERASE_WRITE_LOCK}
      |-> ##[17:40] lockBits[region_q];
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock bit not set");
  property p_lock_keep; flashReadyFlag && $past(flashReadyFlag) |-> $stable(lockBits); endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock bits changed while idle");
  property p_done_pulse; latchWriteDone |=> !latchWriteDone; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("write done too long");
  property p_no_early; latchWrite.valid |=> !latchWriteDone [*2]; endproperty
  a_no_early: assert property (p_no_early) else $error("write done too early");
  property p_write_wait; latchWriteDone |-> wrAge_q == 8'(readWaitStates) + 8'h04; endproperty
  a_write_wait: assert property (p_write_wait) else $error("write wait states wrong");
  property p_desc_total; descIndex == flash_seq_pkg::DESC_IDX_TOTAL |=> descData == 32'h0000_0400; endproperty
  a_desc_total: assert property (p_desc_total) else $error("descriptor size wrong");
  c_lock_err: cover property (take && hit);
  c_lock_set: cover property ($rose(lockBits[1]));
  c_done: cover property (latchWriteDone);
endmodule : flash_seq_props
bind flash_program_latch_sequencer flash_seq_props #(.LOCK_REGIONS(LOCK_REGIONS)) u_props (
  .clock(clock), .rst(rst), .latchWrite(latchWrite), .latchWriteDone(latchWriteDone),
  .readWaitStates(readWaitStates),
  .commandReq(commandReq), .flashReadyFlag(flashReadyFlag), .lockErrorFlag(lockErrorFlag),
  .lockBits(lockBits), .descIndex(descIndex), .descData(descData));

/* File: wait_counter.sv */
`timescale 1ns/1ns
module wait_counter #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);

  typedef struct packed {
    logic             busy;
    logic [WIDTH-1:0] remain;
    logic             done;
  } state_type;

  state_type state_q;
  state_type state_d;

  always_comb begin
    state_d      = state_q;
    state_d.done = 1'b0;
    if (start) begin
      state_d.busy   = 1'b1;
      state_d.remain = count;
    end else if (state_q.busy) begin
      if (state_q.remain == '0) begin
        state_d.busy = 1'b0;
        state_d.done = 1'b1;
      end else begin
        state_d.remain = state_q.remain - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign done = state_q.done;

endmodule : wait_counter
